// >>> rtl/tpsc_pkg.sv
// Package for the shared test pin controller.
// Assumes one system clock domain and one test clock domain.
package tpsc_pkg;
   // ****************************************
   // Scan state machine
   // ****************************************
   typedef enum logic [3:0] {
      TPSC_RESET = 4'h0, TPSC_IDLE = 4'h1, TPSC_SEL_DR = 4'h2,
      TPSC_CAP_DR = 4'h3, TPSC_SH_DR = 4'h4, TPSC_EX1_DR = 4'h5,
      TPSC_PAU_DR = 4'h6, TPSC_EX2_DR = 4'h7, TPSC_UPD_DR = 4'h8,
      TPSC_SEL_IR = 4'h9, TPSC_CAP_IR = 4'hA, TPSC_SH_IR = 4'hB,
      TPSC_EX1_IR = 4'hC, TPSC_PAU_IR = 4'hD, TPSC_EX2_IR = 4'hE,
      TPSC_UPD_IR = 4'hF
   } tpsc_state_t;

   // ****************************************
   // Widths and codes
   // ****************************************
   localparam int TPSC_NODES = 16;
   localparam int TPSC_SEL_W = 4;
   localparam int TPSC_BSR_W = 8;
   localparam int TPSC_IR_W = 2;
   localparam logic [1:0] TPSC_IR_BYPASS = 2'h3;
   localparam logic [1:0] TPSC_IR_PROBE = 2'h1;
   localparam logic [1:0] TPSC_IR_EXTEST = 2'h0;
   localparam logic [1:0] TPSC_IR_RESET = 2'h3;
   localparam logic [1:0] TPSC_IR_CAPT = 2'h1;
   localparam logic [7:0] TPSC_PSEL_RESET = 8'h00;

   // Pin pair for a two-way pin
   typedef struct packed {
      logic o;
      logic oe;
   } tpsc_pin_t;
endpackage : tpsc_pkg

// >>> rtl/tpsc_top.sv
// Shared test pin control: scan state machine, pin sharing, probes.
// Assumes the test clock comes from an external scan controller and
// user logic drives the shared pins when they are not in test use.
`timescale 1ns/1ps

// What this block does
// - Flexible mode: TMS low claims test pins
// - Hold test use until logic-reset state
// - Five TCK high TMS reaches logic-reset
// - Dedicated mode: standard TMS, no sharing
// - TDI shifts scan and probe select
// - TDO shifts boundary scan data out
// - Two probes show any selected node
// - Probe pins revert to user I/O
// - Probe disable, sticky until reset, blocks both probes
module tpsc_top (
   // Clocks and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic tck_i,
   // Mode and test pins
   input wire logic dedicated_i,
   input wire logic tms_i,
   input wire logic tdi_i,
   // Internal nodes and user data
   input wire logic [15:0] node_i,
   input wire logic user_tdo_i,
   input wire logic user_tdo_oe_i,
   input wire logic user_pra_i,
   input wire logic user_pra_oe_i,
   input wire logic user_prb_i,
   input wire logic user_prb_oe_i,
   input wire logic probe_kill_i,
   // Pin drives
   output logic tdo_o,
   output logic tdo_oe_o,
   output logic probe_out_a_o,
   output logic probe_out_a_oe_o,
   output logic probe_out_b_o,
   output logic probe_out_b_oe_o,
   output logic test_use_o,
   output logic probe_dis_o
);
   // ****************************************
   // Test clock domain
   // ****************************************
   tpsc_pkg::tpsc_state_t st;
   tpsc_pkg::tpsc_state_t next_st;
   logic [1:0] ir;
   logic [1:0] ir_sh;
   logic [7:0] bsr;
   logic [7:0] psel;
   logic [7:0] psel_sh;
   logic tdo_neg;
   logic tdo_en_neg;
   logic claim;
   logic next_claim;
   logic [2:0] tms_hi;

   // Standard TAP next-state table
   always_comb begin
      case (st)
         tpsc_pkg::TPSC_RESET: next_st = tms_i ? tpsc_pkg::TPSC_RESET
                                                : tpsc_pkg::TPSC_IDLE;
         tpsc_pkg::TPSC_IDLE: next_st = tms_i ? tpsc_pkg::TPSC_SEL_DR
                                               : tpsc_pkg::TPSC_IDLE;
         tpsc_pkg::TPSC_SEL_DR: next_st = tms_i ? tpsc_pkg::TPSC_SEL_IR
                                                 : tpsc_pkg::TPSC_CAP_DR;
         tpsc_pkg::TPSC_CAP_DR, tpsc_pkg::TPSC_SH_DR:
            next_st = tms_i ? tpsc_pkg::TPSC_EX1_DR : tpsc_pkg::TPSC_SH_DR;
         tpsc_pkg::TPSC_EX1_DR: next_st = tms_i ? tpsc_pkg::TPSC_UPD_DR
                                                 : tpsc_pkg::TPSC_PAU_DR;
         tpsc_pkg::TPSC_PAU_DR: next_st = tms_i ? tpsc_pkg::TPSC_EX2_DR
                                                 : tpsc_pkg::TPSC_PAU_DR;
         tpsc_pkg::TPSC_EX2_DR: next_st = tms_i ? tpsc_pkg::TPSC_UPD_DR
                                                 : tpsc_pkg::TPSC_SH_DR;
         tpsc_pkg::TPSC_SEL_IR: next_st = tms_i ? tpsc_pkg::TPSC_RESET
                                                 : tpsc_pkg::TPSC_CAP_IR;
         tpsc_pkg::TPSC_CAP_IR, tpsc_pkg::TPSC_SH_IR:
            next_st = tms_i ? tpsc_pkg::TPSC_EX1_IR : tpsc_pkg::TPSC_SH_IR;
         tpsc_pkg::TPSC_EX1_IR: next_st = tms_i ? tpsc_pkg::TPSC_UPD_IR
                                                 : tpsc_pkg::TPSC_PAU_IR;
         tpsc_pkg::TPSC_PAU_IR: next_st = tms_i ? tpsc_pkg::TPSC_EX2_IR
                                                 : tpsc_pkg::TPSC_PAU_IR;
         tpsc_pkg::TPSC_EX2_IR: next_st = tms_i ? tpsc_pkg::TPSC_UPD_IR
                                                 : tpsc_pkg::TPSC_SH_IR;
         default: next_st = tms_i ? tpsc_pkg::TPSC_SEL_DR
                                  : tpsc_pkg::TPSC_IDLE;
      endcase
   end

   wire force_rst = tms_i && (tms_hi == 3'h4);
   wire claim_set = !tms_i || dedicated_i;
   assign next_claim = dedicated_i ? 1'b1 :
      (force_rst || (next_st == tpsc_pkg::TPSC_RESET && !claim_set)) ? 1'b0
      : (claim | claim_set);
   wire probe_ir = (ir == tpsc_pkg::TPSC_IR_PROBE);
   wire ext_ir = (ir == tpsc_pkg::TPSC_IR_EXTEST);

   always_ff @(posedge tck_i) begin
      if (rst_i) begin
         st <= tpsc_pkg::TPSC_RESET;
         tms_hi <= 3'h0;
         claim <= 1'b0;
      end else begin
         st <= force_rst ? tpsc_pkg::TPSC_RESET : next_st;
         tms_hi <= !tms_i ? 3'h0 : (tms_hi == 3'h4 ? tms_hi : tms_hi + 3'h1);
         claim <= next_claim;
      end
   end

   // TDI feeds scan and probe select
   always_ff @(posedge tck_i) begin
      if (rst_i || st == tpsc_pkg::TPSC_RESET) begin
         ir <= tpsc_pkg::TPSC_IR_RESET;
         ir_sh <= tpsc_pkg::TPSC_IR_CAPT;
         psel <= tpsc_pkg::TPSC_PSEL_RESET;
         psel_sh <= tpsc_pkg::TPSC_PSEL_RESET;
         bsr <= 8'h00;
      end else begin
         if (st == tpsc_pkg::TPSC_CAP_IR) ir_sh <= tpsc_pkg::TPSC_IR_CAPT;
         if (st == tpsc_pkg::TPSC_SH_IR) ir_sh <= {tdi_i, ir_sh[1]};
         if (st == tpsc_pkg::TPSC_UPD_IR) ir <= ir_sh;
         if (st == tpsc_pkg::TPSC_CAP_DR && ext_ir) bsr <= node_i[7:0];
         if (st == tpsc_pkg::TPSC_SH_DR && ext_ir) bsr <= {tdi_i, bsr[7:1]};
         if (st == tpsc_pkg::TPSC_SH_DR && probe_ir)
            psel_sh <= {tdi_i, psel_sh[7:1]};
         if (st == tpsc_pkg::TPSC_UPD_DR && probe_ir) psel <= psel_sh;
      end
   end

   wire shifting = (st == tpsc_pkg::TPSC_SH_DR) || (st == tpsc_pkg::TPSC_SH_IR);
   wire scan_bit = (st == tpsc_pkg::TPSC_SH_IR) ? ir_sh[0] :
      ext_ir ? bsr[0] : probe_ir ? psel_sh[0] : 1'b0;

   always_ff @(negedge tck_i) begin
      if (rst_i) begin
         tdo_neg <= 1'b0;
         tdo_en_neg <= 1'b0;
      end else begin
         tdo_neg <= scan_bit;
         tdo_en_neg <= shifting;
      end
   end

   // ****************************************
   // System clock side
   // ****************************************
   logic [1:0] claim_s;
   logic [1:0] tdo_s;
   logic [1:0] tdoe_s;
   logic [7:0] psel_a;
   logic [7:0] psel_m;
   logic [7:0] psel_b;
   logic [1:0] kill_s;
   logic probe_dis;

   // Two-flop crossings; the select word is only taken once two
   // successive samples agree, so a torn update never reaches a probe
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         claim_s <= 2'h0;
         tdo_s <= 2'h0;
         tdoe_s <= 2'h0;
         kill_s <= 2'h0;
         psel_a <= 8'h00;
         psel_m <= 8'h00;
         psel_b <= 8'h00;
      end else begin
         claim_s <= {claim_s[0], claim};
         tdo_s <= {tdo_s[0], tdo_neg};
         tdoe_s <= {tdoe_s[0], tdo_en_neg};
         kill_s <= {kill_s[0], probe_kill_i};
         psel_a <= psel;
         psel_m <= psel_a;
         psel_b <= (psel_a == psel_m) ? psel_m : psel_b;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) probe_dis <= 1'b0;
      else if (kill_s[1]) probe_dis <= 1'b1;
   end

   wire probe_on_a = psel_b[7] && !probe_dis;
   wire probe_on_b = psel_b[6] && !probe_dis;
   wire node_a = node_i[psel_b[3:0]];
   wire node_b = node_i[psel_b[5:2]];

   // Pin drive registers
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         tdo_o <= 1'b0;
         tdo_oe_o <= 1'b0;
         probe_out_a_o <= 1'b0;
         probe_out_a_oe_o <= 1'b0;
         probe_out_b_o <= 1'b0;
         probe_out_b_oe_o <= 1'b0;
         test_use_o <= 1'b0;
         probe_dis_o <= 1'b0;
      end else begin
         test_use_o <= claim_s[1];
         probe_dis_o <= probe_dis;
         tdo_o <= claim_s[1] ? tdo_s[1] : user_tdo_i;
         tdo_oe_o <= claim_s[1] ? tdoe_s[1] : user_tdo_oe_i;
         // probe pin falls back to user
         probe_out_a_o <= probe_on_a ? node_a : user_pra_i;
         probe_out_a_oe_o <= probe_on_a | user_pra_oe_i;
         probe_out_b_o <= probe_on_b ? node_b : user_prb_i;
         probe_out_b_oe_o <= probe_on_b | user_prb_oe_i;
      end
   end
endmodule // tpsc_top

// >>> verification/test_tpsc_top.sv
// Bench for tpsc_top with a scan controller model.
// Assumes the checker is bound by its own file.
`timescale 1ns/1ps
module test_tpsc_top;
   logic mclk_i = 1'h0;
   logic rst_i = 1'h1;
   logic dedicated_i = 1'h0;
   logic probe_kill_i = 1'h0;
   logic [15:0] node_i = 16'h0000;
   logic user_tdo_i = 1'h0, user_tdo_oe_i = 1'h0, user_pra_i = 1'h0;
   logic user_pra_oe_i = 1'h0, user_prb_i = 1'h0, user_prb_oe_i = 1'h0;
   logic tck_i, tms_i, tdi_i, tdo_o, tdo_oe_o, test_use_o, probe_dis_o;
   logic probe_out_a_o, probe_out_a_oe_o, probe_out_b_o, probe_out_b_oe_o;
   logic [7:0] q, s;
   int n_mismatch = 0;
   int comparisons = 0;
   wire [3:0] pins = {probe_out_b_oe_o, probe_out_a_oe_o, probe_out_b_o,
      probe_out_a_o};
   wire [3:0] uview = {user_prb_oe_i, user_pra_oe_i, user_prb_i, user_pra_i};
   // System clock
   always #10 mclk_i = ~mclk_i;
   tpsc_scan_ctl i_ctl (.tck_o(tck_i), .tms_o(tms_i), .tdi_o(tdi_i));
   tpsc_top i_dut (.*);
   task automatic final_report;
      if (n_mismatch == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   // Bounded wait; a timeout ends the run
   task automatic wait_use(input logic v);
      for (int k = 0; k < 60 && test_use_o !== v; k++) @(posedge mclk_i);
      cmp(test_use_o, v);
      if (test_use_o !== v) final_report();
   endtask
   // Probe pins expected from a select byte
   function automatic logic [3:0] pexp(logic [7:0] e, logic [15:0] n);
      return {e[6], e[7], n[e[5:2]], n[e[3:0]]};
   endfunction
   // Scan from idle, LSB first, TDO caught before each shift
   task automatic scan(input logic ir, input logic [7:0] v, input int n);
      i_ctl.step(1'h1, 1'h0);
      if (ir) i_ctl.step(1'h1, 1'h0);
      repeat (2) i_ctl.step(1'h0, 1'h0);
      for (int i = 0; i < n; i++) begin
         q[i] = tdo_o;
         i_ctl.step(i == n - 1, v[i]);
      end
      i_ctl.step(1'h1, 1'h0);
      i_ctl.step(1'h0, 1'h0);
   endtask
   initial begin
      void'($urandom(32'hadd0f873));
      fork i_ctl.step(1'h1, 1'h0); join_none
      repeat (6) @(posedge mclk_i);
      rst_i <= 1'h0;
      {user_prb_oe_i, user_prb_i, user_pra_oe_i, user_pra_i, user_tdo_oe_i,
         user_tdo_i} <= 6'($urandom);
      repeat (4) @(posedge mclk_i);
      cmp({test_use_o, probe_dis_o}, 2'h0);
      // claim, shift, four highs hold, fifth frees
      i_ctl.step(1'h0, 1'h0);
      wait_use(1'h1);
      i_ctl.step(1'h1, 1'h0);
      repeat (2) i_ctl.step(1'h0, 1'h0);
      cmp(tdo_oe_o, 1'h1);
      repeat (4) i_ctl.step(1'h1, 1'h0);
      cmp(test_use_o, 1'h1);
      i_ctl.step(1'h1, 1'h0);
      wait_use(1'h0);
      repeat (4) @(posedge mclk_i);
      cmp({tdo_oe_o, tdo_o}, {user_tdo_oe_i, user_tdo_i});
      // captured nodes come out on TDO
      i_ctl.step(1'h0, 1'h0);
      scan(1'h1, {6'h00, tpsc_pkg::TPSC_IR_EXTEST}, 2);
      @(posedge mclk_i) node_i <= 16'($urandom);
      scan(1'h0, 8'($urandom), 8);
      cmp(q, node_i[7:0]);
      // select shifted in on TDI, probes follow live nodes
      scan(1'h1, {6'h00, tpsc_pkg::TPSC_IR_PROBE}, 2);
      s = 8'($urandom) | 8'hC0;
      scan(1'h0, s, 8);
      repeat (4) begin
         @(posedge mclk_i) node_i <= 16'($urandom);
         repeat (5) @(posedge mclk_i);
         cmp(pins, pexp(s, node_i));
      end
      scan(1'h0, s & 8'h3F, 8);
      cmp(pins, uview);
      scan(1'h0, s, 8);
      @(posedge mclk_i) probe_kill_i <= 1'h1;
      @(posedge mclk_i) probe_kill_i <= 1'h0;
      repeat (6) @(posedge mclk_i);
      cmp({probe_dis_o, pins}, {1'h1, uview});
      @(posedge mclk_i) dedicated_i <= 1'h1;
      repeat (6) i_ctl.step(1'h1, 1'h0);
      cmp(test_use_o, 1'h1);
      final_report();
   end
endmodule // test_tpsc_top

// >>> verification/tpsc_checker.sv
// Port checker for tpsc_top, bound below.
// Assumes one system clock domain and a synchronous reset.
`timescale 1ns/1ps
module tpsc_checker (
   // Watched ports
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic dedicated_i,
   input wire logic probe_kill_i,
   input wire logic user_tdo_oe_i,
   input wire logic user_pra_oe_i,
   input wire logic user_prb_oe_i,
   input wire logic tdo_oe_o,
   input wire logic probe_out_a_oe_o,
   input wire logic probe_out_b_oe_o,
   input wire logic test_use_o,
   input wire logic probe_dis_o
);
   logic [3:0] kh;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   // Kill history, since the kill pin is synchronised first
   always_ff @(posedge mclk_i) kh <= rst_i ? 4'h0 : {kh[2:0], probe_kill_i};
   chk_dis_sticky: assert property (probe_dis_o |=> probe_dis_o)
      else $error("disable dropped");
   chk_kill_sets: assert property (probe_kill_i |-> ##[1:4] probe_dis_o)
      else $error("kill ignored");
   chk_dis_cause: assert property ($rose(probe_dis_o) |-> kh != 4'h0)
      else $error("disable without kill");
   chk_dis_pra: assert property (probe_dis_o && $past(probe_dis_o, 3)
      && $past(user_pra_oe_i, 3) == user_pra_oe_i
      |-> probe_out_a_oe_o == user_pra_oe_i) else $error("probe A shown");
   chk_dis_prb: assert property (probe_dis_o && $past(probe_dis_o, 3)
      && $past(user_prb_oe_i, 3) == user_prb_oe_i
      |-> probe_out_b_oe_o == user_prb_oe_i) else $error("probe B shown");
   chk_tdo_user: assert property (!test_use_o && !$past(test_use_o, 3)
      && $past(user_tdo_oe_i, 3) == user_tdo_oe_i
      |-> tdo_oe_o == user_tdo_oe_i) else $error("TDO not released");
   chk_ded_hold: assert property (dedicated_i && $past(dedicated_i, 6)
      && !$past(rst_i, 6) |-> test_use_o) else $error("dedicated lost");
   chk_use_fall: assert property ($fell(test_use_o) |->
      !$past(dedicated_i, 4)) else $error("released in dedicated");
   cov_claim: cover property ($rose(test_use_o));
   cov_release: cover property ($fell(test_use_o));
   cov_disable: cover property ($rose(probe_dis_o));
endmodule // tpsc_checker
bind tpsc_top tpsc_checker i_chk (.mclk_i, .rst_i, .dedicated_i,
   .probe_kill_i, .user_tdo_oe_i, .user_pra_oe_i, .user_prb_oe_i, .tdo_oe_o,
   .probe_out_a_oe_o, .probe_out_b_oe_o, .test_use_o, .probe_dis_o);

// >>> verification/tpsc_scan_ctl.sv
// Scan controller model driving the test pins.
// Assumes the bench calls step; TCK rests low between calls.
`timescale 1ns/1ps
module tpsc_scan_ctl (
   // Test pins
   output logic tck_o = 1'h0,
   output logic tms_o = 1'h1,
   output logic tdi_o = 1'h0
);
   // change on low TCK, hold past rise
   task automatic step(input logic m, input logic d);
      tms_o = m;
      tdi_o = d;
      #15 tck_o = 1'h1;
      #15 tck_o = 1'h0;
      #15 tdi_o = ~d; // Stale data must not look valid
      #135;
   endtask
endmodule // tpsc_scan_ctl
